// [inc/rhwa_pkg.sv]
// constants, field layouts and carrier types of the hour/weekday/date alarm
// assumes a 50 MHz system clock and an AXI4-Lite master on the register side
//
// What this block does
// R1 - hour alarm is an 8-bit read/write register tied to the hour counter
// R2 - hour compare_enable 1 compares hour; 0 leaves hour out of matching
// R3 - alarm only when every enabled alarm field of the set equals its counter
// R4 - software writes hour alarm values 00 to 23 only
// R5 - power-on reset clears compare_enable of hour, weekday and date alarms
// R6 - alarm target fields keep contents through reset; never forced
// R7 - hour layout: enable, read-zero bit, tens 0-2, units 0-9
// R8 - weekday layout: enable bit 7, zero bits 6-3, day code bits 2-0
// R9 - software writes day codes 0 (Sunday) to 6 (Saturday) only
// R10 - weekday enable 1 compares day code with the weekday counter
// R11 - date enable 1 compares the date target with the date counter
// R12 - software writes dates 01 to 31 that exist in the month
// R13 - date layout: enable bit 7, zero bit 6, tens bits 5-4, units 3-0
// R14 - alarm flag set with interrupt enable 1 raises the interrupt
// R15 - alarm signalled once per entry into a full match
package rhwa_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  OFS_HOUR    = 8'h00;
    localparam logic [7:0]  OFS_WEEKDAY = 8'h04;
    localparam logic [7:0]  OFS_DATE    = 8'h08;
    localparam logic [7:0]  OFS_STATUS  = 8'h0c;
    localparam logic [7:0]  OFS_MASK    = 8'h10;

    // ----------------------------------------------------------------
    // field layouts
    // ----------------------------------------------------------------
    localparam int          ENB_BIT     = 7;
    localparam int          FLAG_BIT    = 0;
    localparam logic [7:0]  HOUR_WR     = 8'hbf;
    localparam logic [7:0]  WEEKDAY_WR  = 8'h87;
    localparam logic [7:0]  DATE_WR     = 8'hbf;
    localparam logic [7:0]  HOUR_CMP    = 8'h3f;
    localparam logic [7:0]  WEEKDAY_CMP = 8'h07;
    localparam logic [7:0]  DATE_CMP    = 8'h3f;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } rhwa_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } rhwa_axi_rsp_t;

    typedef struct packed {
        logic [7:0] hour_counter;
        logic [7:0] weekday_counter;
        logic [7:0] date_counter;
    } rhwa_time_t;

    typedef struct packed {
        logic [7:0]        hour_alarm;
        logic [7:0]        weekday_alarm;
        logic [7:0]        date_alarm;
        logic              alarm_flag;
        logic              alarm_interrupt_enable;
        logic              match_q;
        logic              event_q;
        logic              aw_got;
        logic [ADDR_W-1:0] awaddr;
        logic              w_got;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } rhwa_state_t;

endpackage

// [verilog/rhwa_alarm.sv]
// hour, weekday and date alarm compare with an AXI4-Lite register slave
// assumes live counters and the seconds/minutes/month match arrive
// synchronous to i_sys_clk
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps

module rhwa_alarm (
    input  wire logic                   i_sys_clk,     // 50 MHz clock
    input  wire logic                   i_srst,        // sync reset, high
    input  wire rhwa_pkg::rhwa_axi_req_t i_axi,        // bus from master
    output rhwa_pkg::rhwa_axi_rsp_t     o_axi,         // bus to master
    input  wire rhwa_pkg::rhwa_time_t    i_time,       // live counters
    input  wire logic                   i_ext_enabled, // other alarms enabled
    input  wire logic                   i_ext_match,   // other enabled alarms hit
    output logic                        o_alarm_event, // one-cycle match pulse
    output logic                        o_irq          // level interrupt
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // a disabled field never blocks the match
    function automatic logic field_hit(input logic [7:0] alarm,
                                       input logic [7:0] live,
                                       input logic [7:0] cmp);
        field_hit = !alarm[rhwa_pkg::ENB_BIT] || ((alarm & cmp) == (live & cmp));
    endfunction

    function automatic logic [31:0] byte_word(input logic [7:0] b);
        byte_word = {24'h0, b};
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    rhwa_pkg::rhwa_state_t s;
    rhwa_pkg::rhwa_state_t next_s;

    logic hour_hit;
    logic weekday_hit;
    logic date_hit;
    logic any_enabled;
    logic full_match;
    logic aw_take;
    logic w_take;
    logic aw_have;
    logic w_have;
    logic wr_do;
    logic rd_take;
    logic [rhwa_pkg::ADDR_W-1:0] wa;
    logic [31:0] wd;
    logic        wlane;

    // ----------------------------------------------------------------
    // match
    // ----------------------------------------------------------------
    // R2 hour compare gate
    assign hour_hit    = field_hit(s.hour_alarm, i_time.hour_counter,
                                   rhwa_pkg::HOUR_CMP);
    // R10 weekday compare gate
    assign weekday_hit = field_hit(s.weekday_alarm, i_time.weekday_counter,
                                   rhwa_pkg::WEEKDAY_CMP);
    // R11 date compare gate
    assign date_hit    = field_hit(s.date_alarm, i_time.date_counter,
                                   rhwa_pkg::DATE_CMP);
    // with nothing enabled there is nothing to match, so no alarm
    assign any_enabled = s.hour_alarm[rhwa_pkg::ENB_BIT]
                       | s.weekday_alarm[rhwa_pkg::ENB_BIT]
                       | s.date_alarm[rhwa_pkg::ENB_BIT]
                       | i_ext_enabled;
    // R3 all enabled fields coincide
    assign full_match  = any_enabled & hour_hit & weekday_hit & date_hit
                       & i_ext_match;

    // ----------------------------------------------------------------
    // bus handshakes
    // ----------------------------------------------------------------
    assign o_axi.awready = !s.aw_got && !s.bvalid;
    assign o_axi.wready  = !s.w_got && !s.bvalid;
    assign o_axi.arready = !s.rvalid;
    assign o_axi.bvalid  = s.bvalid;
    assign o_axi.bresp   = s.bresp;
    assign o_axi.rvalid  = s.rvalid;
    assign o_axi.rdata   = s.rdata;
    assign o_axi.rresp   = s.rresp;

    assign aw_take = i_axi.awvalid && o_axi.awready;
    assign w_take  = i_axi.wvalid && o_axi.wready;
    assign aw_have = s.aw_got || aw_take;
    assign w_have  = s.w_got || w_take;
    assign wr_do   = aw_have && w_have;
    assign rd_take = i_axi.arvalid && o_axi.arready;
    assign wa      = s.aw_got ? s.awaddr : i_axi.awaddr;
    assign wd      = s.w_got ? s.wdata : i_axi.wdata;
    assign wlane   = s.w_got ? s.wstrb[0] : i_axi.wstrb[0];

    // R14 interrupt gated by enable
    assign o_irq         = s.alarm_flag & s.alarm_interrupt_enable;
    assign o_alarm_event = s.event_q;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        // R15 rising edge of match only
        next_s.match_q = full_match;
        next_s.event_q = full_match && !s.match_q;

        if (aw_take) begin
            next_s.aw_got = 1'b1;
            next_s.awaddr = i_axi.awaddr;
        end
        if (w_take) begin
            next_s.w_got = 1'b1;
            next_s.wdata = i_axi.wdata;
            next_s.wstrb = i_axi.wstrb;
        end
        if (s.bvalid && i_axi.bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s.rvalid && i_axi.rready) begin
            next_s.rvalid = 1'b0;
        end

        if (wr_do) begin
            next_s.aw_got = 1'b0;
            next_s.w_got  = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = rhwa_pkg::RESP_OKAY;
            unique case (wa)
                // R1 R7 hour alarm write, bit 6 stays zero
                rhwa_pkg::OFS_HOUR: begin
                    if (wlane) begin
                        next_s.hour_alarm = wd[7:0] & rhwa_pkg::HOUR_WR;
                    end
                end
                // R8 weekday write, bits 6-3 stay zero
                rhwa_pkg::OFS_WEEKDAY: begin
                    if (wlane) begin
                        next_s.weekday_alarm = wd[7:0] & rhwa_pkg::WEEKDAY_WR;
                    end
                end
                // R13 date write, bit 6 stays zero
                rhwa_pkg::OFS_DATE: begin
                    if (wlane) begin
                        next_s.date_alarm = wd[7:0] & rhwa_pkg::DATE_WR;
                    end
                end
                rhwa_pkg::OFS_STATUS: begin
                    if (wlane && wd[rhwa_pkg::FLAG_BIT]) begin
                        next_s.alarm_flag = 1'b0;
                    end
                end
                rhwa_pkg::OFS_MASK: begin
                    if (wlane) begin
                        next_s.alarm_interrupt_enable = wd[rhwa_pkg::FLAG_BIT];
                    end
                end
                default: begin
                    next_s.bresp = rhwa_pkg::RESP_SLVERR;
                end
            endcase
        end

        // a new match beats a clear in the same cycle
        if (full_match && !s.match_q) begin
            next_s.alarm_flag = 1'b1;
        end

        if (rd_take) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = rhwa_pkg::RESP_OKAY;
            unique case (i_axi.araddr)
                rhwa_pkg::OFS_HOUR:    next_s.rdata = byte_word(s.hour_alarm);
                rhwa_pkg::OFS_WEEKDAY: next_s.rdata = byte_word(s.weekday_alarm);
                rhwa_pkg::OFS_DATE:    next_s.rdata = byte_word(s.date_alarm);
                rhwa_pkg::OFS_STATUS:  next_s.rdata = {31'h0, s.alarm_flag};
                rhwa_pkg::OFS_MASK: begin
                    next_s.rdata = {31'h0, s.alarm_interrupt_enable};
                end
                default: begin
                    next_s.rdata = 32'h0;
                    next_s.rresp = rhwa_pkg::RESP_SLVERR;
                end
            endcase
        end

        if (i_srst) begin
            // R5 R6 the enables clear; targets are left alone
            // read-only bits are cleared as well, so a target never written
            // still reads zero there
            next_s.hour_alarm    = s.hour_alarm & rhwa_pkg::HOUR_WR;
            next_s.weekday_alarm = s.weekday_alarm & rhwa_pkg::WEEKDAY_WR;
            next_s.date_alarm    = s.date_alarm & rhwa_pkg::DATE_WR;
            next_s.hour_alarm[rhwa_pkg::ENB_BIT]    = 1'b0;
            next_s.weekday_alarm[rhwa_pkg::ENB_BIT] = 1'b0;
            next_s.date_alarm[rhwa_pkg::ENB_BIT]    = 1'b0;
            next_s.alarm_flag             = 1'b0;
            next_s.alarm_interrupt_enable = 1'b0;
            next_s.match_q = 1'b0;
            next_s.event_q = 1'b0;
            next_s.aw_got  = 1'b0;
            next_s.awaddr  = 8'h00;
            next_s.w_got   = 1'b0;
            next_s.wdata   = 32'h0;
            next_s.wstrb   = 4'h0;
            next_s.bvalid  = 1'b0;
            next_s.bresp   = rhwa_pkg::RESP_OKAY;
            next_s.rvalid  = 1'b0;
            next_s.rdata   = 32'h0;
            next_s.rresp   = rhwa_pkg::RESP_OKAY;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        s <= next_s;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);

    sequence match_rise_s;
        !full_match ##1 full_match;
    endsequence

    sequence event_once_s;
        o_alarm_event ##1 !o_alarm_event;
    endsequence

    event_on_rise_a: assert property (match_rise_s |=> event_once_s) // R15
        else $error("alarm event missing after match rise");

    event_needs_match_a: assert property ( // R3
        o_alarm_event |-> $past(full_match) && s.alarm_flag)
        else $error("alarm event without full match");

    irq_gate_a: assert property ( // R14
        full_match && !s.match_q && s.alarm_interrupt_enable
        && !(wr_do && wa == rhwa_pkg::OFS_MASK) |=> o_irq)
        else $error("interrupt not raised for enabled flag");

    irq_quiet_a: assert property ( // R14
        wr_do && wa == rhwa_pkg::OFS_MASK && wlane && !wd[rhwa_pkg::FLAG_BIT] |=> !o_irq)
        else $error("interrupt raised while disabled");

    hour_compare_a: assert property ( // R2
        full_match && s.hour_alarm[7] |->
        s.hour_alarm[5:0] == i_time.hour_counter[5:0])
        else $error("match with hour differing");

    weekday_compare_a: assert property ( // R10
        full_match && s.weekday_alarm[7] |->
        s.weekday_alarm[2:0] == i_time.weekday_counter[2:0])
        else $error("match with weekday differing");

    date_compare_a: assert property ( // R11
        full_match && s.date_alarm[7] |->
        s.date_alarm[5:0] == i_time.date_counter[5:0])
        else $error("match with date differing");

    zero_bits_a: assert property ( // R7 R8 R13
        s.hour_alarm[6] == 1'b0 && s.weekday_alarm[6:3] == 4'h0
        && s.date_alarm[6] == 1'b0)
        else $error("read-only alarm bit not zero");

    write_answer_a: assert property (wr_do |=> o_axi.bvalid) // R1
        else $error("write response missing");

    enb_reset_a: assert property ( // R5
        @(posedge i_sys_clk) disable iff (1'b0)
        i_srst |=> !s.hour_alarm[7] && !s.weekday_alarm[7] && !s.date_alarm[7])
        else $error("enable bit survived reset");

    target_keep_a: assert property ( // R6
        @(posedge i_sys_clk) disable iff (1'b0)
        i_srst |=> $stable(s.hour_alarm[5:0]) && $stable(s.date_alarm[5:0])
        && $stable(s.weekday_alarm[2:0]))
        else $error("alarm target changed by reset");

    resp_hold_a: assert property ( // R1
        o_axi.bvalid && !i_axi.bready |=> o_axi.bvalid && $stable(o_axi.bresp))
        else $error("write response dropped before accepted");

    read_hold_a: assert property ( // R1
        o_axi.rvalid && !i_axi.rready |=> o_axi.rvalid && $stable(o_axi.rdata))
        else $error("read data dropped before accepted");

    lane_gate_a: assert property ( // R1
        wr_do && !wlane |=> $stable(s.hour_alarm))
        else $error("hour alarm written with lane off");

    flag_set_a: assert property (full_match && !s.match_q |=> s.alarm_flag) // R15
        else $error("alarm flag not set on match entry");

    event_single_a: assert property (o_alarm_event |=> !o_alarm_event) // R15
        else $error("alarm event longer than one cycle");

    status_clear_a: assert property ( // R14
        wr_do && wa == rhwa_pkg::OFS_STATUS && wlane && wd[rhwa_pkg::FLAG_BIT]
        && !(full_match && !s.match_q) |=> !s.alarm_flag)
        else $error("alarm flag not cleared by write of one");

endmodule

// [verification/rhwa_alarm_bench.sv]
// self-checking bench for the hour/weekday/date alarm block
// assumes the bench alone drives every port; registers reached over AXI4-Lite
`timescale 1ns/1ps

`define CHK(got, want) begin compares++; if ((got) !== (want)) begin fail_count++; \
    $display("MISMATCH %0t got %h want %h", $time, got, want); end end

module rhwa_alarm_bench;
    logic                    i_sys_clk  = 1'b0;
    logic                    i_srst     = 1'b1;
    rhwa_pkg::rhwa_axi_req_t req        = '0;
    rhwa_pkg::rhwa_axi_rsp_t rsp;
    rhwa_pkg::rhwa_time_t    tm         = '0;
    rhwa_pkg::rhwa_time_t    nt;
    logic                    ext_en     = 1'b0;
    logic                    ext_m      = 1'b0;
    logic                    ev;
    logic                    irq;
    logic                    msk        = 1'b1;
    int                      fail_count = 0;
    int                      compares   = 0;
    logic [31:0]             rd;
    logic [1:0]              rs;
    logic [7:0]              h, w, d;
    logic [7:0]              ofs [3]    = '{8'h00, 8'h04, 8'h08};
    logic [7:0]              lw  [3]    = '{8'he3, 8'hfe, 8'hf1};
    logic [7:0]              wm  [3]    = '{8'ha3, 8'h86, 8'hb1};
    logic [7:0]              tv  [3]    = '{8'h95, 8'h83, 8'ha9};

    always #10 i_sys_clk = ~i_sys_clk;

    rhwa_alarm i_dut (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_axi(req), .o_axi(rsp),
        .i_time(tm), .i_ext_enabled(ext_en), .i_ext_match(ext_m), .o_alarm_event(ev),
        .o_irq(irq));

    // ----------------------------------------------------------------
    // closing and bus tasks
    // ----------------------------------------------------------------
    task automatic wrap_up();
        if (fail_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic give_up();
        fail_count++;
        $display("MISMATCH %0t bus wait ran out", $time);
        wrap_up();
    endtask

    // both channels offered together; each released once taken
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] dv, output logic [1:0] r,
                          input logic [3:0] st = 4'hf);
        @(posedge i_sys_clk);
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= {24'h000000, dv};
        req.wstrb   <= st;
        req.bready  <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(posedge i_sys_clk);
            if (rsp.bvalid) begin
                r = rsp.bresp;
                req.bready <= 1'b0;
                return;
            end
            if (req.awvalid && rsp.awready) begin
                req.awvalid <= 1'b0;
            end
            if (req.wvalid && rsp.wready) begin
                req.wvalid <= 1'b0;
            end
        end
        give_up();
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] r);
        @(posedge i_sys_clk);
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(posedge i_sys_clk);
            if (rsp.rvalid) begin
                dv = rsp.rdata;
                r = rsp.rresp;
                req.rready <= 1'b0;
                return;
            end
            if (req.arvalid && rsp.arready) begin
                req.arvalid <= 1'b0;
            end
        end
        give_up();
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e,
                          input logic [1:0] er = rhwa_pkg::RESP_OKAY);
        axi_rd(a, rd, rs);
        `CHK(rd, e)
        `CHK(rs, er)
    endtask

    // ----------------------------------------------------------------
    // expectation helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] bcd(input int v);
        return 8'((v / 10) * 16 + v % 10);
    endfunction

    function automatic logic full_match(input logic [7:0] hh, ww, dd,
                                        input rhwa_pkg::rhwa_time_t t, input logic xe, xm);
        logic any;
        logic eq;
        any = hh[7] | ww[7] | dd[7] | xe;
        eq  = (!hh[7] || hh[5:0] == t.hour_counter[5:0]) && xm &&
              (!ww[7] || ww[2:0] == t.weekday_counter[2:0]) &&
              (!dd[7] || dd[5:0] == t.date_counter[5:0]);
        return any && eq;
    endfunction

    // match held low while targets change, so each trial is a fresh entry
    task automatic trial(input logic [7:0] th, tw, td, input rhwa_pkg::rhwa_time_t t,
                         input logic xe, xm);
        logic want;
        @(posedge i_sys_clk);
        ext_m <= 1'b0;
        axi_wr(rhwa_pkg::OFS_HOUR, th, rs);
        axi_wr(rhwa_pkg::OFS_WEEKDAY, tw, rs);
        axi_wr(rhwa_pkg::OFS_DATE, td, rs);
        axi_wr(rhwa_pkg::OFS_STATUS, 8'h01, rs);
        chk_rd(rhwa_pkg::OFS_STATUS, 32'h0); // flag cleared
        want = full_match(th, tw, td, t, xe, xm);
        @(posedge i_sys_clk);
        tm     <= t;
        ext_en <= xe;
        ext_m  <= xm;
        @(posedge i_sys_clk);
        #1;
        `CHK(ev, want) // match rule
        `CHK(irq, want & msk) // interrupt level
        @(posedge i_sys_clk);
        #1;
        `CHK(ev, 1'b0) // single pulse
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(46816));
        repeat (4) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            axi_rd(ofs[k], rd, rs);
            `CHK(rd[7], 1'b0) // enable cleared
            axi_wr(ofs[k], lw[k], rs); // legal targets, read-only bits set
            chk_rd(ofs[k], {24'h0, wm[k]}); // layout
            axi_wr(ofs[k], tv[k], rs);
        end
        axi_wr(8'h14, 8'h01, rs);
        `CHK(rs, rhwa_pkg::RESP_SLVERR) // unmapped write
        chk_rd(8'h14, 32'h0, rhwa_pkg::RESP_SLVERR); // unmapped read
        @(posedge i_sys_clk);
        i_srst <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            chk_rd(ofs[k], {24'h0, tv[k] & 8'h7f}); // targets kept
        end
        axi_wr(rhwa_pkg::OFS_HOUR, 8'h80, rs, 4'h0);
        `CHK(rs, rhwa_pkg::RESP_OKAY) // lane off accepted
        chk_rd(rhwa_pkg::OFS_HOUR, {24'h0, tv[0] & 8'h7f}); // lane off, no write
        axi_wr(rhwa_pkg::OFS_MASK, 8'h01, rs);
        trial(8'h95, 8'h86, 8'hb1, {8'h15, 8'h06, 8'h31}, 1'b0, 1'b1); // all enabled
        @(posedge i_sys_clk);
        ext_m <= 1'b0;
        @(posedge i_sys_clk);
        ext_m <= 1'b1;
        @(posedge i_sys_clk);
        #1;
        `CHK(ev, 1'b1) // re-armed
        trial(8'h15, 8'h82, 8'h01, {8'h09, 8'h02, 8'h17}, 1'b0, 1'b1); // hour ignored
        trial(8'h00, 8'h00, 8'h01, {8'h00, 8'h00, 8'h00}, 1'b0, 1'b1); // none enabled
        for (int k = 0; k < 40; k++) begin
            h = bcd($urandom_range(23)) | {1'($urandom_range(1)), 7'h00}; // hour range
            w = 8'($urandom_range(6)) | {1'($urandom_range(1)), 7'h00}; // day range
            d = bcd($urandom_range(31, 1)) | {1'($urandom_range(1)), 7'h00}; // date range
            nt.hour_counter    = $urandom_range(1) ? (h & 8'h3f) : bcd($urandom_range(23));
            nt.weekday_counter = $urandom_range(1) ? (w & 8'h07) : 8'($urandom_range(6));
            nt.date_counter    = $urandom_range(1) ? (d & 8'h3f) : bcd($urandom_range(31, 1));
            trial(h, w, d, nt, 1'($urandom_range(1)), $urandom_range(3) != 0); // random
        end
        msk = 1'b0;
        axi_wr(rhwa_pkg::OFS_MASK, 8'h00, rs);
        trial(8'ha3, 8'h00, 8'h01, {8'h23, 8'h04, 8'h12}, 1'b0, 1'b1); // masked
        chk_rd(rhwa_pkg::OFS_STATUS, 32'h1); // flag still set
        axi_wr(rhwa_pkg::OFS_MASK, 8'h01, rs);
        `CHK(irq, 1'b1) // unmasked
        axi_wr(rhwa_pkg::OFS_STATUS, 8'h01, rs);
        `CHK(irq, 1'b0) // cleared
        wrap_up();
    end
endmodule
